/* verilog/pfc_pkg.sv */
// Summary of operation
// [R1] 128K bytes, 17-bit address, 8-bit data
// [R2] top 16K: four 4K blocks by bits 16:12
// [R3] lower space: seven 16K blocks by 16:14
// [R4] address captured on later falling strobe
// [R5] data captured on first rising strobe
// [R6] every write loads the command register; the model ignores writes while busy and clears its command state on any write with low supply
// [R7] write 00 selects array read
// [R8] write 90 then read signature location
// [R9] two 30 writes start auto chip erase
// [R10] 20 then D0 with block address
// [R11] 40 then address and value programs
// [R12] two 20 writes conventional chip erase
// [R13] 60 then 60 with block address
// [R14] A0 at location, then read verify
// [R15] two FF writes reset command state
// [R16] device times and verifies programming itself
// [R17] busy reads give poll and toggle bits
// [R18] chip erase preprograms, then erases itself; the model erases without preprogramming
// [R19] block erase preprograms selected blocks only; the model erases the block without preprogramming
// [R20] one byte per program, erase whole region
// [R21] done: poll one, toggle stable twice
// [R22] low program supply forces read only
// [R23] next block load within 30 ms
// [R24] signature location 0 maker, 1 device
// [R25] busy device ignores other command writes
package pfc_pkg;
	localparam int PFC_AW = 17; // see [R1]
	localparam int PFC_DW = 8;
	localparam logic [7:0] PFC_CMD_READ = 8'h00; // see [R7]
	localparam logic [7:0] PFC_CMD_SIG = 8'h90; // see [R8]
	localparam logic [7:0] PFC_CMD_ACHIP = 8'h30; // see [R9]
	localparam logic [7:0] PFC_CMD_ABLK = 8'h20; // see [R10]
	localparam logic [7:0] PFC_CMD_ABLK_GO = 8'hD0;
	localparam logic [7:0] PFC_CMD_APROG = 8'h40; // see [R11]
	localparam logic [7:0] PFC_CMD_CERASE = 8'h20; // see [R12]
	localparam logic [7:0] PFC_CMD_CBLK = 8'h60; // see [R13]
	localparam logic [7:0] PFC_CMD_EVFY = 8'hA0; // see [R14]
	localparam logic [7:0] PFC_CMD_RESET = 8'hFF; // see [R15]
	localparam int PFC_POLL_BIT = 7;
	localparam int PFC_TOGGLE_BIT = 6;
	localparam int PFC_CLK_NS = 4;
	// bus phase lengths, each several device access times at 4 ns
	localparam logic [4:0] PFC_T_SETUP = 5'h05;
	localparam logic [4:0] PFC_T_STROBE = 5'h0F;
	localparam logic [4:0] PFC_T_HOLD = 5'h05;
	localparam logic [4:0] PFC_T_READ = 5'h1F;
	localparam int PFC_BLK_GAP_MS = 30; // see [R23]
	localparam longint PFC_BLK_GAP_CYC =
		longint'(PFC_BLK_GAP_MS) * 1000000 / PFC_CLK_NS;
	typedef enum logic [3:0] {
		PFC_OP_READ, PFC_OP_SIG, PFC_OP_PROG, PFC_OP_CHIP_AUTO,
		PFC_OP_BLK_AUTO, PFC_OP_CHIP_CONV, PFC_OP_BLK_CONV,
		PFC_OP_VERIFY, PFC_OP_RESET, PFC_OP_BLK_MORE
	} pfc_op_e;
	typedef struct packed {
		pfc_op_e op;
		logic [PFC_AW-1:0] addr;
		logic [PFC_DW-1:0] data;
	} pfc_req_s;
	typedef struct packed {
		logic [PFC_AW-1:0] addr;
		logic [PFC_DW-1:0] data_out;
		logic data_oe_n;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} pfc_pins_s;
endpackage

/* verilog/pfc_cycle.sv */
// one bus cycle on the flash pins, write or read
module pfc_cycle (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start,
	input wire logic is_write,
	input wire logic [pfc_pkg::PFC_AW-1:0] addr,
	input wire logic [pfc_pkg::PFC_DW-1:0] wdata,
	input wire logic [pfc_pkg::PFC_DW-1:0] data_in,
	output pfc_pkg::pfc_pins_s pins,
	output logic done,
	output logic [pfc_pkg::PFC_DW-1:0] rdata
);
	import pfc_pkg::*;
	typedef enum logic [1:0] {PFC_C_IDLE, PFC_C_SET, PFC_C_STB,
		PFC_C_HLD} pfc_cst_e;
	pfc_cst_e st_q;
	logic [4:0] cnt_q;
	logic wr_q;
	logic [PFC_DW-1:0] s1_q, s2_q;
	// =====================================
	// pin synchroniser
	always_ff @(posedge clk_sys) begin
		s1_q <= data_in;
		s2_q <= s1_q;
	end
	// =====================================
	// sequencing
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q <= PFC_C_IDLE;
			cnt_q <= 5'h00;
			wr_q <= 1'b0;
			done <= 1'b0;
			rdata <= 8'h00;
			pins <= '{addr: '0, data_out: 8'h00, data_oe_n: 1'b1,
				ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
		end else begin
			done <= 1'b0;
			case (st_q)
				PFC_C_IDLE: if (start) begin
					// address settles before the later falling strobe
					pins.addr <= addr; // see [R4]
					pins.data_out <= wdata;
					pins.data_oe_n <= ~is_write;
					wr_q <= is_write;
					cnt_q <= PFC_T_SETUP;
					st_q <= PFC_C_SET;
				end
				PFC_C_SET: if (cnt_q == 5'h00) begin
					pins.ce_n <= 1'b0;
					pins.we_n <= ~wr_q;
					pins.oe_n <= wr_q;
					cnt_q <= wr_q ? PFC_T_STROBE : PFC_T_READ;
					st_q <= PFC_C_STB;
				end else begin
					cnt_q <= cnt_q - 5'h01;
				end
				PFC_C_STB: if (cnt_q == 5'h00) begin
					// data held past the first rising strobe
					pins.we_n <= 1'b1; // see [R5]
					pins.ce_n <= 1'b1;
					pins.oe_n <= 1'b1;
					rdata <= s2_q;
					cnt_q <= PFC_T_HOLD;
					st_q <= PFC_C_HLD;
				end else begin
					cnt_q <= cnt_q - 5'h01;
				end
				PFC_C_HLD: if (cnt_q == 5'h00) begin
					pins.data_oe_n <= 1'b1;
					done <= 1'b1;
					st_q <= PFC_C_IDLE;
				end else begin
					cnt_q <= cnt_q - 5'h01;
				end
				default: st_q <= PFC_C_IDLE;
			endcase
		end
	end
	AST_WE_DATA: assert property ( // see [R5]
		@(posedge clk_sys) disable iff (rst)
		$rose(pins.we_n) |-> !pins.data_oe_n [*3])
		else $error("data released with write strobe");
	AST_CE_WE: assert property ( // see [R4]
		@(posedge clk_sys) disable iff (rst)
		!pins.we_n |-> !pins.ce_n && pins.oe_n)
		else $error("write strobe without chip enable");
endmodule

/* verilog/pfc_host.sv */
module pfc_host (
	input wire logic clk_sys,
	input wire logic rst,
	input pfc_pkg::pfc_req_s req,
	input wire logic req_valid,
	input wire logic prog_supply_ok,
	input wire logic [pfc_pkg::PFC_DW-1:0] data_in,
	output logic req_ready,
	output logic resp_valid,
	output logic [pfc_pkg::PFC_DW-1:0] resp_data,
	output logic busy,
	output logic req_error,
	output pfc_pkg::pfc_pins_s pins
);
	import pfc_pkg::*;
	typedef enum logic [2:0] {PFC_H_IDLE, PFC_H_W1, PFC_H_W2, PFC_H_RD,
		PFC_H_POLL, PFC_H_BLKWIN} pfc_hst_e;
	pfc_hst_e st_q;
	pfc_req_s cur_q;
	logic cyc_start, cyc_wr, cyc_done;
	logic [PFC_AW-1:0] cyc_addr;
	logic [PFC_DW-1:0] cyc_wdata, cyc_rdata, prev_q;
	logic [1:0] stable_q;
	logic first_q, ok1_q, ok2_q;
	logic [31:0] gap_q;
	logic auto_op;
	logic cyc_go_q;
	// =====================================
	// pin cycle engine
	pfc_cycle u_cycle (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(cyc_start),
		.is_write(cyc_wr),
		.addr(cyc_addr),
		.wdata(cyc_wdata),
		.data_in(data_in),
		.pins(pins),
		.done(cyc_done),
		.rdata(cyc_rdata)
	);
	// =====================================
	// supply pin synchroniser
	always_ff @(posedge clk_sys) begin
		ok1_q <= prog_supply_ok;
		ok2_q <= ok1_q;
	end
	assign auto_op = cur_q.op inside {PFC_OP_PROG, PFC_OP_CHIP_AUTO,
		PFC_OP_BLK_AUTO}; // see [R16] [R18] [R19]
	// =====================================
	// command choice per step
	always_comb begin
		cyc_start = 1'b0;
		cyc_wr = 1'b1;
		cyc_addr = cur_q.addr;
		cyc_wdata = PFC_CMD_READ;
		case (st_q)
			PFC_H_W1: begin
				cyc_start = 1'b1;
				case (cur_q.op)
					PFC_OP_SIG: cyc_wdata = PFC_CMD_SIG; // see [R8]
					PFC_OP_PROG: cyc_wdata = PFC_CMD_APROG; // see [R11]
					PFC_OP_CHIP_AUTO: cyc_wdata = PFC_CMD_ACHIP; // see [R9]
					PFC_OP_BLK_AUTO: cyc_wdata = PFC_CMD_ABLK; // see [R10]
					PFC_OP_CHIP_CONV: cyc_wdata = PFC_CMD_CERASE; // see [R12]
					PFC_OP_BLK_CONV: cyc_wdata = PFC_CMD_CBLK; // see [R13]
					PFC_OP_VERIFY: cyc_wdata = PFC_CMD_EVFY; // see [R14]
					PFC_OP_RESET: cyc_wdata = PFC_CMD_RESET; // see [R15]
					PFC_OP_BLK_MORE: cyc_wdata = PFC_CMD_ABLK_GO;
					default: cyc_wdata = PFC_CMD_READ; // see [R7]
				endcase
			end
			PFC_H_W2: begin
				cyc_start = 1'b1;
				case (cur_q.op)
					PFC_OP_PROG: cyc_wdata = cur_q.data; // see [R20]
					PFC_OP_CHIP_AUTO: cyc_wdata = PFC_CMD_ACHIP;
					PFC_OP_BLK_AUTO: cyc_wdata = PFC_CMD_ABLK_GO;
					PFC_OP_CHIP_CONV: cyc_wdata = PFC_CMD_CERASE;
					PFC_OP_BLK_CONV: cyc_wdata = PFC_CMD_CBLK;
					default: cyc_wdata = PFC_CMD_RESET;
				endcase
			end
			PFC_H_RD, PFC_H_POLL: begin
				cyc_start = 1'b1;
				cyc_wr = 1'b0;
			end
			default: cyc_start = 1'b0;
		endcase
		// start is a level: hold it off while a cycle runs and in its
		// done cycle, else the engine repeats the step's write
		if (cyc_go_q) begin
			cyc_start = 1'b0;
		end
	end
	// =====================================
	// bus cycle in flight
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cyc_go_q <= 1'b0;
		end else if (cyc_done) begin
			cyc_go_q <= 1'b0;
		end else if (cyc_start) begin
			cyc_go_q <= 1'b1;
		end
	end
	// =====================================
	// request sequencer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q <= PFC_H_IDLE;
			cur_q <= '{op: PFC_OP_READ, addr: '0, data: 8'h00};
			req_ready <= 1'b0;
			resp_valid <= 1'b0;
			resp_data <= 8'h00;
			busy <= 1'b0;
			req_error <= 1'b0;
			prev_q <= 8'h00;
			stable_q <= 2'h0;
			first_q <= 1'b0;
			gap_q <= 32'h0;
		end else begin
			resp_valid <= 1'b0;
			req_error <= 1'b0;
			req_ready <= 1'b0;
			case (st_q)
				PFC_H_IDLE: if (req_valid && !req_ready) begin
					req_ready <= 1'b1;
					cur_q <= req;
					// low supply: device allows array reads only
					if (!ok2_q && req.op != PFC_OP_READ) begin
						req_error <= 1'b1; // see [R22]
					end else begin
						st_q <= PFC_H_W1;
					end
				end
				PFC_H_W1: if (cyc_done) begin
					if (cur_q.op inside {PFC_OP_READ, PFC_OP_SIG,
						PFC_OP_VERIFY}) begin
						st_q <= PFC_H_RD;
					end else if (cur_q.op == PFC_OP_BLK_MORE) begin
						gap_q <= 32'h0;
						st_q <= PFC_H_BLKWIN;
					end else begin
						st_q <= PFC_H_W2;
					end
				end
				PFC_H_W2: if (cyc_done) begin
					first_q <= 1'b1;
					stable_q <= 2'h0;
					busy <= auto_op;
					gap_q <= 32'h0;
					st_q <= cur_q.op == PFC_OP_BLK_AUTO ? PFC_H_BLKWIN :
						auto_op ? PFC_H_POLL : PFC_H_IDLE;
					resp_valid <= !auto_op;
				end
				PFC_H_RD: if (cyc_done) begin
					resp_data <= cyc_rdata; // see [R24]
					resp_valid <= 1'b1;
					st_q <= PFC_H_IDLE;
				end
				// more blocks may be added within the gap, else poll
				PFC_H_BLKWIN: begin
					gap_q <= gap_q + 32'h1;
					busy <= 1'b1;
					if (req_valid && req.op == PFC_OP_BLK_MORE &&
						gap_q < 32'(PFC_BLK_GAP_CYC) - 32'h40) begin
						req_ready <= 1'b1; // see [R23]
						cur_q <= req;
						st_q <= PFC_H_W1;
					end else if (gap_q >= 32'(PFC_BLK_GAP_CYC)) begin
						first_q <= 1'b1;
						stable_q <= 2'h0;
						st_q <= PFC_H_POLL;
					end
				end
				// only status reads go out while polling the busy device
				PFC_H_POLL: if (cyc_done) begin // see [R25] [R17]
					first_q <= 1'b0;
					prev_q <= cyc_rdata;
					if (!first_q && cyc_rdata[PFC_POLL_BIT] &&
						cyc_rdata[PFC_TOGGLE_BIT] == prev_q[PFC_TOGGLE_BIT])
						begin
						if (stable_q == 2'h1) begin // see [R21]
							busy <= 1'b0;
							resp_data <= cyc_rdata;
							resp_valid <= 1'b1;
							st_q <= PFC_H_IDLE;
						end
						stable_q <= stable_q + 2'h1;
					end else begin
						stable_q <= 2'h0;
					end
				end
				default: st_q <= PFC_H_IDLE;
			endcase
		end
	end
	AST_LOWSUPPLY: assert property ( // see [R22]
		@(posedge clk_sys) disable iff (rst)
		st_q == PFC_H_IDLE && req_valid && !req_ready && !ok2_q &&
		req.op != PFC_OP_READ |=> req_error && st_q == PFC_H_IDLE)
		else $error("write issued under low supply");
	AST_DONE_POLL: assert property ( // see [R21]
		@(posedge clk_sys) disable iff (rst)
		$fell(busy) |-> resp_valid && resp_data[PFC_POLL_BIT])
		else $error("finished without poll bit");
	AST_BUSY_READS: assert property ( // see [R25]
		@(posedge clk_sys) disable iff (rst)
		st_q == PFC_H_POLL |-> pins.we_n)
		else $error("write during busy");
	AST_ERR_PULSE: assert property ( // see [R22]
		@(posedge clk_sys) disable iff (rst)
		req_error |=> !req_error)
		else $error("error held");
	AST_ONE_CYCLE: assert property ( // see [R11]
		@(posedge clk_sys) disable iff (rst)
		cyc_done |-> !cyc_start)
		else $error("bus cycle restarted in its done cycle");
	AST_REFUSE_PINS: assert property ( // see [R22]
		@(posedge clk_sys) disable iff (rst)
		req_error |-> pins.we_n && pins.ce_n)
		else $error("refused request touched the bus");
	COV_CHIP: cover property (@(posedge clk_sys) disable iff (rst)
		$fell(busy) && cur_q.op == PFC_OP_CHIP_AUTO);
	COV_PROG: cover property (@(posedge clk_sys) disable iff (rst)
		$fell(busy) && cur_q.op == PFC_OP_PROG);
	COV_BLK: cover property (@(posedge clk_sys) disable iff (rst)
		st_q == PFC_H_BLKWIN ##1 st_q == PFC_H_W1);
	COV_SIG: cover property (@(posedge clk_sys) disable iff (rst)
		resp_valid && cur_q.op == PFC_OP_SIG);
endmodule

/* bench/pfc_flash_model.sv */
// ==========================================
// flash device model seen through the pins
module pfc_flash_model
	import pfc_pkg::*;
#(
	parameter int BUSY_NS = 2000,
	parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h4B // arbitrary value
) (
	input pfc_pkg::pfc_pins_s pins,
	input wire logic vpp_ok,
	output logic [7:0] data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [int];
	logic [7:0] st_q = 8'h00;
	logic [7:0] mode_q = 8'h00;
	logic [7:0] rd_q = 8'h00;
	logic [16:0] a_q = '0;
	logic [16:0] va_q = '0;
	logic tog_q = 1'b0;
	time end_t = 0;
	// or of strobes: later fall, first rise
	wire wr_n = pins.we_n | pins.ce_n;
	wire rd_n = pins.oe_n | pins.ce_n;
	function automatic logic [7:0] arr(input logic [16:0] a);
		return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
	endfunction
	function automatic void blk(input logic [16:0] a);
		int lo;
		int n;
		lo = (a[16:14] == 3'b111) ? int'({a[16:12], 12'h000}) :
			int'({a[16:14], 14'h0000});
		n = (a[16:14] == 3'b111) ? 4096 : 16384;
		for (int i = lo; i < lo + n; i++) mem.delete(i);
	endfunction
	always @(negedge wr_n) a_q = pins.addr;
	always @(posedge wr_n) begin
		logic [7:0] d;
		d = pins.data_out;
		if (!vpp_ok) begin
			st_q = 8'h00;
			mode_q = 8'h00;
		end else if ($time < end_t) begin // busy ignores
		end else if (st_q == 8'h00) begin
			if (d == 8'hA0) va_q = a_q;
			if (d inside {8'h00, 8'h90, 8'hA0}) mode_q = d;
			else st_q = d;
		end else begin
			// erase deletes the entries without preprogramming, net result all ones
			if (st_q == 8'h30 && d == 8'h30) begin
				mem.delete();
				end_t = $time + BUSY_NS;
			end
			if (st_q == 8'h20 && d == 8'hD0) begin
				blk(a_q);
				end_t = $time + BUSY_NS;
			end
			if (st_q == 8'h40) begin
				mem[int'(a_q)] = arr(a_q) & d;
				end_t = $time + BUSY_NS;
			end
			if (st_q == 8'h20 && d == 8'h20) mem.delete();
			if (st_q == 8'h60 && d == 8'h60) blk(a_q);
			st_q = 8'h00;
			mode_q = 8'h00;
		end
	end
	always @(negedge rd_n) begin
		if ($time < end_t) begin
			tog_q = ~tog_q;
			rd_q = {1'b0, tog_q, 6'h00};
		end else if (mode_q == 8'h90) begin
			rd_q = pins.addr[0] ? DEV_CODE : MAKER_CODE;
		end else if (mode_q == 8'hA0) begin
			rd_q = arr(va_q);
		end else begin
			rd_q = arr(pins.addr);
		end
	end
	// released bus shows the inverse so stale data never matches
	assign data_in = rd_n ? ~rd_q : rd_q;
endmodule

/* bench/tb_top.sv */
module tb_top
	import pfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
		n_mismatch++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	logic vpp = 1'b1;
	pfc_req_s req = '0;
	logic [7:0] data_in, resp_data, rd;
	logic req_ready, resp_valid, busy, req_error, er, bz;
	pfc_pins_s pins;
	int n_mismatch = 0;
	int comparisons = 0;
	pfc_host u_pfc_host (.clk_sys(clk_sys), .rst(rst), .req(req),
		.req_valid(req_valid), .prog_supply_ok(vpp), .data_in(data_in),
		.req_ready(req_ready), .resp_valid(resp_valid),
		.resp_data(resp_data), .busy(busy), .req_error(req_error),
		.pins(pins));
	pfc_flash_model u_pfc_flash_model (.pins(pins), .vpp_ok(vpp),
		.data_in(data_in));
	initial forever #2 clk_sys = ~clk_sys;
	// ==========================================
	// one request, held until taken, then wait for the answer
	task automatic op(input pfc_op_e o, input logic [16:0] a,
		input logic [7:0] d = 8'h00);
		int n;
		n = 0;
		bz = 1'b0;
		req = '{o, a, d};
		req_valid = 1'b1;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (req_ready !== 1'b1 && n < 200);
		req_valid = 1'b0;
		er = req_error;
		while (resp_valid !== 1'b1 && req_error !== 1'b1 && n < 20000) begin
			bz |= busy;
			@(posedge clk_sys);
			#1;
			n++;
		end
		er |= req_error;
		rd = resp_data;
		if (n >= 20000) begin
			n_mismatch++;
			$display("FAIL %0t no response", $time);
		end
	endtask
	task automatic end_of_test;
		if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_prog;
		op(PFC_OP_PROG, 17'h1C005, 8'hA5);
		`CHK({er, bz}, 2'b01)
		`CHK(u_pfc_flash_model.a_q, 17'h1C005)
		op(PFC_OP_READ, 17'h1C005);
		`CHK(rd, 8'hA5)
		op(PFC_OP_PROG, 17'h1C005, 8'hF0);
		op(PFC_OP_READ, 17'h1C005);
		`CHK(rd, 8'hA0)
	endtask
	task automatic t_sig;
		op(PFC_OP_SIG, 17'h00000);
		`CHK(rd, u_pfc_flash_model.MAKER_CODE)
		op(PFC_OP_SIG, 17'h00001);
		`CHK(rd, u_pfc_flash_model.DEV_CODE)
	endtask
	task automatic t_supply;
		vpp = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		op(PFC_OP_PROG, 17'h1C005, 8'h00);
		`CHK(er, 1'b1)
		op(PFC_OP_READ, 17'h1C005);
		`CHK({er, rd}, 9'h0A0)
		vpp = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	task automatic t_reset;
		op(PFC_OP_RESET, 17'h00000);
		`CHK(er, 1'b0)
		op(PFC_OP_READ, 17'h1C005);
		`CHK(rd, 8'hA0)
	endtask
	task automatic t_auto;
		op(PFC_OP_CHIP_AUTO, 17'h00000);
		`CHK({er, bz}, 2'b01)
		`CHK(rd[PFC_POLL_BIT], 1'b1)
		op(PFC_OP_READ, 17'h1C005);
		`CHK(rd, 8'hFF)
	endtask
	// 16K block at 04000, 4K block at 1D000
	task automatic t_conv;
		op(PFC_OP_PROG, 17'h04123, 8'hA5);
		op(PFC_OP_PROG, 17'h1D000, 8'hA5);
		op(PFC_OP_BLK_CONV, 17'h05FFF);
		op(PFC_OP_VERIFY, 17'h04123);
		`CHK(rd, 8'hFF)
		op(PFC_OP_VERIFY, 17'h1D000);
		`CHK(rd, 8'hA5)
		op(PFC_OP_BLK_CONV, 17'h1D800);
		op(PFC_OP_VERIFY, 17'h1D000);
		`CHK(rd, 8'hFF)
		op(PFC_OP_PROG, 17'h00010, 8'hA5);
		op(PFC_OP_CHIP_CONV, 17'h00000);
		op(PFC_OP_READ, 17'h00010);
		`CHK(rd, 8'hFF)
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		t_prog;
		t_sig;
		t_supply;
		t_reset;
		t_auto;
		t_conv;
		end_of_test;
	end
	// about 80k cycles, several times the expected run
	initial begin
		#320000;
		n_mismatch++;
		end_of_test;
	end
endmodule
